/* File: sim/sst_master_model.sv */
// external synchronous master: makes the shift clock and samples data
`timescale 1ns/1ps
module sst_master_model (
  output logic      sclk,  // shift clock, low outside frames
  input  wire logic sdata  // data line as seen on the wire
);
  initial sclk = 1'b0;
  // sample while low, then the selected shift edge (rising, or falling with CKPOL set) asks for the next bit
  task automatic frame(input int n, output logic [8:0] got);
    got = 9'h000;
    for (int i = 0; i < n; i++) begin
      #24 got[i] = sdata;
      sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask
endmodule

/* File: sim/sst_monitor.sv */
// port assertions for the slave transmitter
`timescale 1ns/1ps
module sst_monitor (
  input wire logic aclk,           // clock
  input wire logic aresetn,        // reset, active low
  input wire logic s_axi_awvalid,  // aw valid
  input wire logic s_axi_awready,  // aw ready
  input wire logic s_axi_wvalid,   // w valid
  input wire logic s_axi_wready,   // w ready
  input wire logic s_axi_bvalid,   // b valid
  input wire logic s_axi_arvalid,  // ar valid
  input wire logic s_axi_arready,  // ar ready
  input wire logic s_axi_rvalid,   // r valid
  input wire logic shift_clock_o,  // clock pin out
  input wire logic shift_clock_oe, // clock pin enable
  input wire logic data_pin_o,     // data pin out
  input wire logic data_pin_oe,    // data pin enable
  input wire logic irq,            // interrupt
  input wire logic wake,           // wake pulse
  input wire logic vector_req      // vector pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wake_once;
    wake ##1 !wake;
  endsequence
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_clock_undriven: assert property (!shift_clock_oe && !shift_clock_o)
    else $error("slave drives shift clock");
  chk_idle_high: assert property (!data_pin_oe |-> data_pin_o)
    else $error("data line not idle high");
  chk_wake_pulse: assert property (wake |-> wake_once)
    else $error("wake not a single pulse");
  chk_vector_wake: assert property (vector_req |-> wake)
    else $error("vector without wake");
  chk_vector_irq: assert property (vector_req |-> ##[0:3] irq)
    else $error("vector without interrupt");
  chk_wake_sends: assert property (wake |-> ##[0:6] data_pin_oe)
    else $error("no word after wake hand-over");
  chk_write_start: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_status: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule
bind sst_top sst_monitor sst_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .shift_clock_o,
  .shift_clock_oe, .data_pin_o, .data_pin_oe, .irq, .wake, .vector_req);

/* File: sim/tb.sv */
// self-checking bench for the slave serial transmitter
`timescale 1ns/1ps
`include "sst_consts.svh"
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sclk, so, soe, dpo, dpoe, irq, wake, vreq, line;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [31:0] rdata, rd;
  logic [8:0]  got;
  logic [7:0]  cfg [2] = '{8'hB0, 8'h10};
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  int          wakes = 0;
  int          vecs = 0;
  always #2 aclk = ~aclk;
  // pull-up on the data wire
  assign line = dpoe ? dpo : 1'b1;
  sst_top sst_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .shift_clock_i(sclk),
    .shift_clock_o(so), .shift_clock_oe(soe), .data_pin_o(dpo), .data_pin_oe(dpoe), .irq(irq),
    .wake(wake), .vector_req(vreq));
  sst_master_model sst_master_model_i (.sclk(sclk), .sdata(line));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bs = bresp;
    if (bvalid !== 1'b1) mismatches++;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    if (rvalid !== 1'b1) mismatches++;
    rd = rdata;
    rs = rresp;
    chk(nm, rd, exp);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic fr(input int n, input logic [8:0] exp);
    @(posedge aclk);
    #1;
    sst_master_model_i.frame(n, got);
    chk("frame", {23'h0, got}, {23'h0, exp});
    @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (vreq === 1'b1) vecs++;
    if (cyc == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("txsc reset", `SST_OFF_TXSC, 32'h02);
    rchk("pirq reset", `SST_OFF_PIRQ, 32'h02);
    rchk("unmapped", 8'h40, 32'h0);
    chk("unmapped resp", {30'h0, rs}, 32'h2);
    wr(8'h40, 8'hFF);
    chk("unmapped bresp", {30'h0, bs}, 32'h2);
    wr(`SST_OFF_RXSC, 8'h80);
    chk("okay bresp", {30'h0, bs}, 32'h0);
    wr(`SST_OFF_INTCTL, 8'hC0);
    wr(`SST_OFF_PIRQ, 8'h01);
    foreach (cfg[i]) begin
      wr(`SST_OFF_TXSC, cfg[i]);
      wr(`SST_OFF_TXHOLD, 8'h11 + 8'(i));
      idle(12);
      chk("oe inactive", {31'h0, dpoe}, 32'h0);
    end
    rchk("flag cleared", `SST_OFF_PIRQ, 32'h01);
    wr(`SST_OFF_TXSC, 8'h30);
    idle(6);
    rchk("shift busy", `SST_OFF_TXSC, 32'h30);
    rchk("flag set", `SST_OFF_PIRQ, 32'h03);
    chk("irq", {31'h0, irq}, 32'h1);
    fr(8, 9'h012);
    idle(8);
    rchk("shift empty", `SST_OFF_TXSC, 32'h32);
    wr(`SST_OFF_TXHOLD, 8'hA5);
    wr(`SST_OFF_TXHOLD, 8'h3C);
    wr(`SST_OFF_POWER, 8'h01);
    rchk("second waits", `SST_OFF_PIRQ, 32'h01);
    chk("no wake yet", wakes, 32'h0);
    fr(8, 9'h0A5);
    idle(6);
    chk("wake", wakes, 32'h1);
    chk("vector", vecs, 32'h1);
    rchk("flag after", `SST_OFF_PIRQ, 32'h03);
    rchk("awake", `SST_OFF_POWER, 32'h0);
    fr(8, 9'h03C);
    wr(`SST_OFF_TXSC, 8'h71);
    wr(`SST_OFF_TXHOLD, 8'h5A);
    idle(6);
    fr(9, 9'h15A);
    // falling shift edge selected in the rate control register
    wr(`SST_OFF_RATECTL, 8'h10);
    rchk("rate", `SST_OFF_RATECTL, 32'h10);
    wr(`SST_OFF_TXHOLD, 8'hC3);
    idle(6);
    fr(9, 9'h1C3);
    chk("no wake awake", wakes, 32'h1);
    complete_run();
  end
endmodule

/* File: src/sst_consts.svh */
// register offsets, field positions and reset values of the slave transmitter
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH
`define SST_ADDR_W        8
`define SST_OFF_TXSC      8'h00
`define SST_OFF_RXSC      8'h04
`define SST_OFF_RATECTL   8'h08
`define SST_OFF_RXHOLD    8'h0C
`define SST_OFF_TXHOLD    8'h10
`define SST_OFF_DIVHI     8'h14
`define SST_OFF_DIVLO     8'h18
`define SST_OFF_INTCTL    8'h1C
`define SST_OFF_PIRQ      8'h20
`define SST_OFF_POWER     8'h24
`define SST_TXSC_CLOCK_SOURCE_SELECT     7
`define SST_TXSC_TX9      6
`define SST_TXSC_TRANSMITTER_ENABLE     5
`define SST_TXSC_SYNC     4
`define SST_TXSC_SHIFT_REGISTER_EMPTY     1
`define SST_TXSC_NINTH_TRANSMIT_BIT     0
`define SST_TXSC_WMASK    8'hFD
`define SST_RXSC_SERIAL_PORT_ENABLE     7
`define SST_RXSC_SINGLE_RECEIVE_ENABLE     5
`define SST_RXSC_CONTINUOUS_RECEIVE_ENABLE     4
`define SST_RXSC_WMASK    8'hF9
`define SST_RATE_CKPOL    4
`define SST_RATE_WMASK    8'h1B
`define SST_INT_GIE       7
`define SST_INT_PERIPHERAL_INTERRUPT_ENABLE      6
`define SST_PIRQ_TXIE     0
`define SST_PIRQ_TXIF     1
`define SST_POWER_SLEEP   0
`define SST_RST_BYTE      8'h00
`define SST_IDLE_LEVEL    1'b1
`define SST_RESP_OKAY     2'h0
`define SST_RESP_SLVERR   2'h2
`define SST_BITS_NARROW   4'h8
`define SST_BITS_WIDE     4'h9
`endif

/* File: src/sst_pkg.sv */
// types shared by the slave transmitter modules
package sst_pkg;
  typedef logic [7:0] sst_byte_t;
  typedef logic [8:0] sst_word_t;
  typedef logic [1:0] sst_resp_t;
  typedef enum logic [1:0] {
    SST_SH_IDLE  = 2'b01,
    SST_SH_SHIFT = 2'b10
  } sst_shift_e;
endpackage

/* File: src/sst_shift_if.sv */
// carrier between the register side and the shift engine
`timescale 1ns/1ps
interface sst_shift_if;
  logic              run;
  logic              load;
  logic              nine;
  logic              fall_edge;
  sst_pkg::sst_word_t word;
  logic              empty;
  logic              data_bit;
  modport ctrl    (output run, load, nine, fall_edge, word, input empty, data_bit);
  modport shifter (input run, load, nine, fall_edge, word, output empty, data_bit);
endinterface

/* File: src/sst_shifter.sv */
// transmit shift register clocked by aclk, stepped on the selected edge of the synchronised shift clock
`timescale 1ns/1ps
`include "sst_consts.svh"
module sst_shifter (
  input  wire logic aclk,      // system clock
  input  wire logic aresetn,   // sync reset, active low
  input  wire logic sclk_sync, // synchronised shift clock
  sst_shift_if.shifter sif     // control from register side
);
  sst_pkg::sst_shift_e state_reg, state_next;
  sst_pkg::sst_word_t  sr_reg, sr_next;
  logic [3:0]          cnt_reg, cnt_next;
  logic                data_reg, data_next;
  logic                prev_reg, prev_next;
  logic                edge_hit;
  logic [3:0]          len;

  assign sif.empty    = (state_reg == sst_pkg::SST_SH_IDLE);
  assign sif.data_bit = data_reg;

  always_comb begin
    prev_next  = sclk_sync;
    edge_hit   = sif.fall_edge ? (prev_reg & ~sclk_sync) : (~prev_reg & sclk_sync);
    len        = sif.nine ? `SST_BITS_WIDE : `SST_BITS_NARROW;
    state_next = state_reg;
    sr_next    = sr_reg;
    cnt_next   = cnt_reg;
    data_next  = data_reg;
    if (!sif.run) begin
      state_next = sst_pkg::SST_SH_IDLE;
      data_next  = `SST_IDLE_LEVEL;
    end else begin
      unique case (state_reg)
        sst_pkg::SST_SH_IDLE: begin
          if (sif.load) begin
            // first bit out at once, lsb first
            data_next  = sif.word[0];
            sr_next    = sif.word >> 1;
            cnt_next   = 4'h1;
            state_next = sst_pkg::SST_SH_SHIFT;
          end
        end
        sst_pkg::SST_SH_SHIFT: begin
          if (edge_hit) begin
            if (cnt_reg == len) begin
              state_next = sst_pkg::SST_SH_IDLE;
              data_next  = `SST_IDLE_LEVEL;
            end else begin
              data_next = sr_reg[0];
              sr_next   = sr_reg >> 1;
              cnt_next  = cnt_reg + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= sst_pkg::SST_SH_IDLE;
      sr_reg    <= '0;
      cnt_reg   <= 4'h0;
      data_reg  <= `SST_IDLE_LEVEL;
      prev_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      sr_reg    <= sr_next;
      cnt_reg   <= cnt_next;
      data_reg  <= data_next;
      prev_reg  <= prev_next;
    end
  end
endmodule

/* File: src/sst_sync2.sv */
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sst_sync2 #(
  parameter int W = 1
) (
  input  wire logic         aclk,    // system clock
  input  wire logic         aresetn, // sync reset, active low
  input  wire logic [W-1:0] d,       // asynchronous input
  output logic      [W-1:0] q        // synchronised output
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule

/* File: src/sst_top.sv */
// synchronous slave serial transmitter with AXI4-Lite register access
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sst_consts.svh"
module sst_top (
  input  wire logic                   aclk,           // system clock
  input  wire logic                   aresetn,        // sync reset, active low
  input  wire logic [`SST_ADDR_W-1:0] s_axi_awaddr,   // write address
  input  wire logic                   s_axi_awvalid,  // write address valid
  output logic                        s_axi_awready,  // write address ready
  input  wire logic [31:0]            s_axi_wdata,    // write data
  input  wire logic [3:0]             s_axi_wstrb,    // write byte enables
  input  wire logic                   s_axi_wvalid,   // write data valid
  output logic                        s_axi_wready,   // write data ready
  output logic [1:0]                  s_axi_bresp,    // write response
  output logic                        s_axi_bvalid,   // write response valid
  input  wire logic                   s_axi_bready,   // write response ready
  input  wire logic [`SST_ADDR_W-1:0] s_axi_araddr,   // read address
  input  wire logic                   s_axi_arvalid,  // read address valid
  output logic                        s_axi_arready,  // read address ready
  output logic [31:0]                 s_axi_rdata,    // read data
  output logic [1:0]                  s_axi_rresp,    // read response
  output logic                        s_axi_rvalid,   // read data valid
  input  wire logic                   s_axi_rready,   // read data ready
  input  wire logic                   shift_clock_i,  // shift clock pin, input
  output logic                        shift_clock_o,  // shift clock pin, output
  output logic                        shift_clock_oe, // shift clock pin, drive enable
  output logic                        data_pin_o,     // data pin, output
  output logic                        data_pin_oe,    // data pin, drive enable
  output logic                        irq,            // transmit interrupt to cpu
  output logic                        wake,           // wake from sleep, pulse
  output logic                        vector_req      // branch to interrupt vector, pulse
);
  sst_shift_if sif ();

  logic sclk_sync;

  // register file
  sst_pkg::sst_byte_t txsc_reg, txsc_next;
  sst_pkg::sst_byte_t rxsc_reg, rxsc_next;
  sst_pkg::sst_byte_t rate_reg, rate_next;
  sst_pkg::sst_byte_t divhi_reg, divhi_next;
  sst_pkg::sst_byte_t divlo_reg, divlo_next;
  sst_pkg::sst_byte_t intctl_reg, intctl_next;
  logic               txie_reg, txie_next;
  logic               sleep_reg, sleep_next;
  sst_pkg::sst_byte_t hold_reg, hold_next;
  logic               hold_full_reg, hold_full_next;
  logic               load_reg, load_next;
  sst_pkg::sst_word_t word_reg, word_next;
  logic               irq_reg, irq_next;
  logic               wake_reg, wake_next;
  logic               vec_reg, vec_next;
  logic               dout_reg, dout_next;
  logic               doe_reg, doe_next;

  // bus state
  logic [`SST_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0]            wdata_reg, wdata_next;
  logic [3:0]             wstrb_reg, wstrb_next;
  logic                   aw_full_reg, aw_full_next;
  logic                   w_full_reg, w_full_next;
  logic                   awready_reg, awready_next;
  logic                   wready_reg, wready_next;
  logic                   bvalid_reg, bvalid_next;
  sst_pkg::sst_resp_t     bresp_reg, bresp_next;
  logic                   arready_reg, arready_next;
  logic                   rvalid_reg, rvalid_next;
  sst_pkg::sst_resp_t     rresp_reg, rresp_next;
  logic [31:0]            rdata_reg, rdata_next;

  logic active;
  logic xfer;
  logic do_wr;
  logic wr_en;
  logic wr_hold;
  logic shift_register_empty;

  function automatic logic addr_mapped(input logic [`SST_ADDR_W-1:0] a);
    unique case (a)
      `SST_OFF_TXSC, `SST_OFF_RXSC, `SST_OFF_RATECTL, `SST_OFF_RXHOLD,
      `SST_OFF_TXHOLD, `SST_OFF_DIVHI, `SST_OFF_DIVLO, `SST_OFF_INTCTL,
      `SST_OFF_PIRQ, `SST_OFF_POWER: addr_mapped = 1'b1;
      default:                       addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [`SST_ADDR_W-1:0] a,
                                  input logic [`SST_ADDR_W-1:0] off,
                                  input logic                   en);
    wr_hit = en && (a == off);
  endfunction

  sst_sync2 #(
    .W (1)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (shift_clock_i),
    .q       (sclk_sync)
  );

  sst_shifter u_shifter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .sclk_sync (sclk_sync),
    .sif       (sif)
  );

  // slave transmit path is live only with clock source select clear
  assign active = rxsc_reg[`SST_RXSC_SERIAL_PORT_ENABLE] & txsc_reg[`SST_TXSC_SYNC]
                & ~txsc_reg[`SST_TXSC_CLOCK_SOURCE_SELECT] & txsc_reg[`SST_TXSC_TRANSMITTER_ENABLE];
  // a write to the holding register in the same cycle defers the hand-over by one cycle
  assign xfer   = active & hold_full_reg & sif.empty & ~load_reg & ~wr_hold;
  assign shift_register_empty   = sif.empty & ~load_reg;

  assign sif.run       = active;
  assign sif.load      = load_reg;
  assign sif.word      = word_reg;
  assign sif.nine      = txsc_reg[`SST_TXSC_TX9];
  assign sif.fall_edge = rate_reg[`SST_RATE_CKPOL];

  // write channel
  always_comb begin
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    do_wr        = aw_full_reg & w_full_reg & ~bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      awaddr_next  = s_axi_awaddr;
      aw_full_next = 1'b1;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      w_full_next = 1'b1;
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_mapped(awaddr_reg) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = ~aw_full_next & ~bvalid_next;
    wready_next  = ~w_full_next & ~bvalid_next;
  end

  // read channel
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = addr_mapped(s_axi_araddr) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
      rdata_next  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `SST_OFF_TXSC:    rdata_next[7:0] = {txsc_reg[7:2], shift_register_empty, txsc_reg[0]};
        `SST_OFF_RXSC:    rdata_next[7:0] = rxsc_reg;
        `SST_OFF_RATECTL: rdata_next[7:0] = rate_reg;
        `SST_OFF_DIVHI:   rdata_next[7:0] = divhi_reg;
        `SST_OFF_DIVLO:   rdata_next[7:0] = divlo_reg;
        `SST_OFF_INTCTL:  rdata_next[7:0] = intctl_reg;
        `SST_OFF_PIRQ:    rdata_next[1:0] = {~hold_full_reg, txie_reg};
        `SST_OFF_POWER:   rdata_next[0]   = sleep_reg;
        default:          rdata_next      = 32'h0000_0000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = ~rvalid_next;
  end

  // register writes, hand-over and sleep
  always_comb begin
    wr_en          = do_wr & wstrb_reg[0];
    wr_hold        = wr_hit(awaddr_reg, `SST_OFF_TXHOLD, wr_en);
    txsc_next      = txsc_reg;
    rxsc_next      = rxsc_reg;
    rate_next      = rate_reg;
    divhi_next     = divhi_reg;
    divlo_next     = divlo_reg;
    intctl_next    = intctl_reg;
    txie_next      = txie_reg;
    sleep_next     = sleep_reg;
    hold_next      = hold_reg;
    hold_full_next = hold_full_reg;
    word_next      = word_reg;
    load_next      = 1'b0;
    wake_next      = 1'b0;
    vec_next       = 1'b0;
    if (wr_hit(awaddr_reg, `SST_OFF_TXSC, wr_en)) begin
      txsc_next = wdata_reg[7:0] & `SST_TXSC_WMASK;
    end
    if (wr_hit(awaddr_reg, `SST_OFF_RXSC, wr_en)) begin
      rxsc_next = wdata_reg[7:0] & `SST_RXSC_WMASK;
    end
    if (wr_hit(awaddr_reg, `SST_OFF_RATECTL, wr_en)) begin
      rate_next = wdata_reg[7:0] & `SST_RATE_WMASK;
    end
    if (wr_hit(awaddr_reg, `SST_OFF_DIVHI, wr_en)) begin
      divhi_next = wdata_reg[7:0];
    end
    if (wr_hit(awaddr_reg, `SST_OFF_DIVLO, wr_en)) begin
      divlo_next = wdata_reg[7:0];
    end
    if (wr_hit(awaddr_reg, `SST_OFF_INTCTL, wr_en)) begin
      intctl_next = wdata_reg[7:0];
    end
    if (wr_hit(awaddr_reg, `SST_OFF_PIRQ, wr_en)) begin
      txie_next = wdata_reg[`SST_PIRQ_TXIE];
    end
    if (wr_hit(awaddr_reg, `SST_OFF_POWER, wr_en)) begin
      sleep_next = wdata_reg[`SST_POWER_SLEEP];
    end
    if (wr_hold) begin
      // new data clears the empty flag; an unsent word is overwritten
      hold_next      = wdata_reg[7:0];
      hold_full_next = 1'b1;
    end
    if (xfer) begin
      // ninth bit captured at hand-over
      word_next      = {txsc_reg[`SST_TXSC_NINTH_TRANSMIT_BIT], hold_reg};
      load_next      = 1'b1;
      hold_full_next = 1'b0;
      if (sleep_reg && txie_reg) begin
        sleep_next = 1'b0;
        wake_next  = 1'b1;
        vec_next   = intctl_reg[`SST_INT_GIE] & intctl_reg[`SST_INT_PERIPHERAL_INTERRUPT_ENABLE];
      end
    end
    irq_next  = ~hold_full_next & txie_next & intctl_next[`SST_INT_GIE] & intctl_next[`SST_INT_PERIPHERAL_INTERRUPT_ENABLE];
    dout_next = active ? sif.data_bit : `SST_IDLE_LEVEL;
    doe_next  = active;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SST_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `SST_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txsc_reg      <= `SST_RST_BYTE;
      rxsc_reg      <= `SST_RST_BYTE;
      rate_reg      <= `SST_RST_BYTE;
      divhi_reg     <= `SST_RST_BYTE;
      divlo_reg     <= `SST_RST_BYTE;
      intctl_reg    <= `SST_RST_BYTE;
      txie_reg      <= 1'b0;
      sleep_reg     <= 1'b0;
      hold_reg      <= `SST_RST_BYTE;
      hold_full_reg <= 1'b0;
      word_reg      <= '0;
      load_reg      <= 1'b0;
      irq_reg       <= 1'b0;
      wake_reg      <= 1'b0;
      vec_reg       <= 1'b0;
      dout_reg      <= `SST_IDLE_LEVEL;
      doe_reg       <= 1'b0;
    end else begin
      txsc_reg      <= txsc_next;
      rxsc_reg      <= rxsc_next;
      rate_reg      <= rate_next;
      divhi_reg     <= divhi_next;
      divlo_reg     <= divlo_next;
      intctl_reg    <= intctl_next;
      txie_reg      <= txie_next;
      sleep_reg     <= sleep_next;
      hold_reg      <= hold_next;
      hold_full_reg <= hold_full_next;
      word_reg      <= word_next;
      load_reg      <= load_next;
      irq_reg       <= irq_next;
      wake_reg      <= wake_next;
      vec_reg       <= vec_next;
      dout_reg      <= dout_next;
      doe_reg       <= doe_next;
    end
  end

  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arready_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rresp    = rresp_reg;
  assign s_axi_rdata    = rdata_reg;
  // slave never drives the shift clock
  assign shift_clock_o  = 1'b0;
  assign shift_clock_oe = 1'b0;
  assign data_pin_o     = dout_reg;
  assign data_pin_oe    = doe_reg;
  assign irq            = irq_reg;
  assign wake           = wake_reg;
  assign vector_req     = vec_reg;
endmodule
